// ---- inc/wdt_cfg.svh ----
// Constants of the keyed watchdog: timing, register offsets, fields and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_HZ 20000000
`define SLOW_OSC_HZ 32000
`define SLOW_OSC_DIV (`MCLK_HZ / `SLOW_OSC_HZ)
`define SOFT_RESET_DELAY_US 100
`define SOFT_RESET_CYCLES ((`SOFT_RESET_DELAY_US * `MCLK_HZ + 999999) / 1000000)

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_WATCHDOG_CONTROL 6'h00
`define OFS_RESET_CAUSE_FLAGS 6'h04
`define OFS_WDT_STATUS 6'h08
`define OFS_IRQ_STATUS 6'h0C
`define OFS_IRQ_CLEAR 6'h10
`define OFS_IRQ_ENABLE 6'h14

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define KEY_MSB 7
`define KEY_LSB 3
`define PERIOD_MSB 2
`define PERIOD_LSB 0
`define KEY_ENABLE 5'h0A
`define KEY_DISABLE 5'h15
`define CONTROL_POR 8'h53
`define WRF_BIT 0
`define STAT_EXPIRY_BIT 0
`define STAT_POWER_DOWN_BIT 1
`define STAT_RUNNING_BIT 2
`define IRQ_OVERFLOW_BIT 0
`define IRQ_KEY_RESET_BIT 1
`define IRQ_SLEEP_WAKE_BIT 2
`define IRQ_COUNT 3
`define COUNT_WIDTH 18
`define DELAY_WIDTH 16

`endif

// ---- inc/wdt_pkg.sv ----
// Types used by the keyed watchdog module.
// Assumes wdt_cfg.svh is on the include path.
`include "wdt_cfg.svh"

package wdt_pkg;

  typedef enum logic [1:0] {
    key_run,
    key_stop,
    key_reset_pending
  } key_mode_type;

  typedef struct packed {
    logic [7:0] control;
    logic watchdog_ctrl_reset_flag;
    logic expiry;
    logic power_down;
    logic [`COUNT_WIDTH-1:0] count;
    key_mode_type mode;
    logic [`DELAY_WIDTH-1:0] delay;
    logic ack;
    logic [31:0] rdata;
    logic device_reset;
    logic pc_sp_reset;
  } wdt_state_type;

endpackage

// ---- verilog/slow_osc_tick.sv ----
// Divider that turns mclk into the slow internal oscillator rate as a one-cycle enable.
// Assumes a single free-running mclk.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module slow_osc_tick #(
  parameter int unsigned DIV = `SLOW_OSC_DIV
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Enable pulse at the slow rate.
  output logic tick
);

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } tick_state_type;

  tick_state_type state;
  tick_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 16'(DIV - 1)) begin
      next_state.count = 16'h0000;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule

// ---- verilog/event_irq.sv ----
// Sticky event status with write-one-to-clear and enable mask onto one level interrupt.
// Assumes event pulses and write strobes are synchronous to mclk.
`timescale 1ns/1ps

module event_irq #(
  parameter int unsigned N = 3
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Events and software access.
  input wire logic [N-1:0] event_set,
  input wire logic clear_wr,
  input wire logic [N-1:0] clear_bits,
  input wire logic enable_wr,
  input wire logic [N-1:0] enable_bits,
  // State.
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
    logic irq;
  } irq_state_type;

  irq_state_type state;
  irq_state_type next_state;

  always_comb begin
    next_state = state;
    if (clear_wr) begin
      next_state.status = state.status & ~clear_bits;
    end
    // A new event wins over a clear in the same cycle.
    next_state.status = next_state.status | event_set;
    if (enable_wr) begin
      next_state.enable = enable_bits;
    end
    next_state.irq = |(next_state.status & next_state.enable);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status = state.status;
  assign enable = state.enable;
  assign irq = state.irq;

endmodule

// ---- verilog/keyed_watchdog.sv ----
// Keyed watchdog timer with reset-cause flag, Wishbone register slave and interrupt.
// Assumes wdt_pkg is compiled first and the core drives its event pulses on mclk.
//
// Operation
// - Count only slow oscillator ticks.
// - Period field selects 2^8 to 2^18.
// - Key 01010B enables, 10101B disables.
// - Other key value forces delayed full reset.
// - Key reset sets flag bit 0.
// - Flag cleared only by software zero.
// - Power-on key enable, period 011.
// - Running overflow resets device, sets expiry.
// - Sleep overflow sets expiry, resets PC/SP.
// - Four events clear the counter.
// - One dedicated clear instruction only.
// - Upper four flag bits read zero.
// - Halt clears counter, resumes if enabled.
// - Power-down cleared by clear, set by halt.
// - Halt clears expiry flag.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module keyed_watchdog #(
  parameter int unsigned OSC_DIV = `SLOW_OSC_DIV,
  parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor core.
  input wire logic clear_watchdog_instruction,
  input wire logic halt_instruction,
  input wire logic sleep_mode,
  input wire logic reset_pin_n,
  // Reset requests and interrupt.
  output logic device_reset,
  output logic pc_sp_reset,
  output logic irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [`COUNT_WIDTH-1:0] period_limit(input logic [2:0] sel);
    logic [4:0] shift;
    begin
      shift = 5'h00;
      case (sel)
        3'h0: shift = 5'h08;
        3'h1: shift = 5'h0A;
        3'h2: shift = 5'h0C;
        3'h3: shift = 5'h0E;
        3'h4: shift = 5'h0F;
        3'h5: shift = 5'h10;
        3'h6: shift = 5'h11;
        default: shift = 5'h12;
      endcase
      period_limit = `COUNT_WIDTH'((19'h00001 << shift) - 19'h00001);
    end
  endfunction

  function automatic logic key_valid(input logic [4:0] key);
    key_valid = (key == `KEY_ENABLE) || (key == `KEY_DISABLE);
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  logic osc_tick;
  logic [`IRQ_COUNT-1:0] irq_events;
  logic [`IRQ_COUNT-1:0] irq_status;
  logic [`IRQ_COUNT-1:0] irq_enable;
  logic bus_req;
  logic bus_wr;
  logic wr_control;
  logic wr_flags;
  logic wr_irq_clear;
  logic wr_irq_enable;

  wdt_pkg::wdt_state_type state;
  wdt_pkg::wdt_state_type next_state;

  slow_osc_tick #(
    .DIV(OSC_DIV)
  ) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(osc_tick)
  );

  event_irq #(
    .N(`IRQ_COUNT)
  ) u_irq (
    .mclk(mclk),
    .arst_n(arst_n),
    .event_set(irq_events),
    .clear_wr(wr_irq_clear),
    .clear_bits(wb_dat_i[`IRQ_COUNT-1:0]),
    .enable_wr(wr_irq_enable),
    .enable_bits(wb_dat_i[`IRQ_COUNT-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign bus_req = wb_cyc_i && wb_stb_i && !state.ack;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_control = bus_wr && (wb_adr_i == `OFS_WATCHDOG_CONTROL);
  assign wr_flags = bus_wr && (wb_adr_i == `OFS_RESET_CAUSE_FLAGS);
  assign wr_irq_clear = bus_wr && (wb_adr_i == `OFS_IRQ_CLEAR);
  assign wr_irq_enable = bus_wr && (wb_adr_i == `OFS_IRQ_ENABLE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic overflow;
  logic key_fire;
  logic counter_clear;
  logic [4:0] key;

  always_comb begin
    next_state = state;
    overflow = 1'b0;
    key_fire = 1'b0;
    counter_clear = 1'b0;
    next_state.ack = bus_req;
    next_state.device_reset = 1'b0;
    next_state.pc_sp_reset = 1'b0;

    if (wr_control) begin
      next_state.control = wb_dat_i[7:0];
    end
    key = next_state.control[`KEY_MSB:`KEY_LSB];

    case (state.mode)
      wdt_pkg::key_run,
      wdt_pkg::key_stop: begin
        if (key == `KEY_ENABLE) begin
          next_state.mode = wdt_pkg::key_run;
        end else if (key == `KEY_DISABLE) begin
          next_state.mode = wdt_pkg::key_stop;
        end else begin
          next_state.mode = wdt_pkg::key_reset_pending;
          next_state.delay = `DELAY_WIDTH'(SOFT_RESET_CYCLES - 1);
          counter_clear = 1'b1;
        end
      end
      wdt_pkg::key_reset_pending: begin
        counter_clear = 1'b1;
        if (state.delay == '0) begin
          key_fire = 1'b1;
          next_state.device_reset = 1'b1;
          next_state.control = `CONTROL_POR;
          next_state.mode = wdt_pkg::key_run;
        end else begin
          next_state.delay = state.delay - `DELAY_WIDTH'(1);
        end
      end
      default: begin
        next_state.mode = wdt_pkg::key_run;
      end
    endcase

    if (state.mode == wdt_pkg::key_run && osc_tick) begin
      if (state.count >= period_limit(state.control[`PERIOD_MSB:`PERIOD_LSB])) begin
        overflow = 1'b1;
        next_state.count = '0;
      end else begin
        next_state.count = state.count + `COUNT_WIDTH'(1);
      end
    end

    if (overflow) begin
      next_state.expiry = 1'b1;
      if (sleep_mode) begin
        next_state.pc_sp_reset = 1'b1;
      end else begin
        next_state.device_reset = 1'b1;
      end
    end

    if (clear_watchdog_instruction) begin
      counter_clear = 1'b1;
      next_state.power_down = 1'b0;
    end
    if (halt_instruction) begin
      counter_clear = 1'b1;
      next_state.power_down = 1'b1;
      next_state.expiry = 1'b0;
    end
    if (!reset_pin_n) begin
      counter_clear = 1'b1;
    end
    if (counter_clear) begin
      next_state.count = '0;
    end

    if (wr_flags && !wb_dat_i[`WRF_BIT]) begin
      next_state.watchdog_ctrl_reset_flag = 1'b0;
    end
    if (key_fire) begin
      next_state.watchdog_ctrl_reset_flag = 1'b1;
    end

    next_state.rdata = 32'h00000000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `OFS_WATCHDOG_CONTROL: next_state.rdata[7:0] = state.control;
        `OFS_RESET_CAUSE_FLAGS: next_state.rdata[`WRF_BIT] = state.watchdog_ctrl_reset_flag;
        `OFS_WDT_STATUS: begin
          next_state.rdata[`STAT_EXPIRY_BIT] = state.expiry;
          next_state.rdata[`STAT_POWER_DOWN_BIT] = state.power_down;
          next_state.rdata[`STAT_RUNNING_BIT] = (state.mode == wdt_pkg::key_run);
        end
        `OFS_IRQ_STATUS: next_state.rdata[`IRQ_COUNT-1:0] = irq_status;
        `OFS_IRQ_ENABLE: next_state.rdata[`IRQ_COUNT-1:0] = irq_enable;
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  // Events come from the cause itself, not from the sticky flags, which may be stale.
  always_comb begin
    irq_events = '0;
    irq_events[`IRQ_OVERFLOW_BIT] = overflow && !sleep_mode;
    irq_events[`IRQ_KEY_RESET_BIT] = key_fire;
    irq_events[`IRQ_SLEEP_WAKE_BIT] = overflow && sleep_mode;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
      state.control <= `CONTROL_POR;
      state.mode <= wdt_pkg::key_run;
    end else begin
      state <= next_state;
    end
  end

  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.rdata;
  assign device_reset = state.device_reset;
  assign pc_sp_reset = state.pc_sp_reset;

endmodule

// ---- dv/wdt_chk.sv ----
// Port checker for keyed_watchdog.
// Assumes wdt_cfg.svh is on the include path and the bind below.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_chk #(
  parameter int unsigned OSC_DIV = 2,
  parameter int unsigned SOFT_RESET_CYCLES = 4
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Bus and core lines.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic clear_watchdog_instruction,
  input wire logic halt_instruction,
  input wire logic sleep_mode,
  input wire logic reset_pin_n,
  // Outputs.
  input wire logic device_reset,
  input wire logic pc_sp_reset,
  input wire logic irq
);
  localparam int KEY_MAX = SOFT_RESET_CYCLES + 4;
  logic taken;
  logic bad_key;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bad_key = taken && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_WATCHDOG_CONTROL
    && wb_dat_i[7:3] != `KEY_ENABLE && wb_dat_i[7:3] != `KEY_DISABLE;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_AFTER_REQ: assert property (taken |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_KEY_RESET: assert property (bad_key |-> ##[1:KEY_MAX] device_reset)
    else $error("bad key did not reset");
  AST_DEV_PULSE: assert property (device_reset |=> !device_reset)
    else $error("device reset not a pulse");
  AST_PCSP_PULSE: assert property (pc_sp_reset |=> !pc_sp_reset)
    else $error("pc sp reset not a pulse");
  AST_ONE_KIND: assert property (!(device_reset && pc_sp_reset))
    else $error("both reset kinds at once");

  COV_DEV: cover property (device_reset);
  COV_PCSP: cover property (pc_sp_reset);
  COV_IRQ: cover property ($rose(irq));
endmodule

bind keyed_watchdog wdt_chk #(.OSC_DIV(OSC_DIV), .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .clear_watchdog_instruction(clear_watchdog_instruction),
  .halt_instruction(halt_instruction), .sleep_mode(sleep_mode),
  .reset_pin_n(reset_pin_n), .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
  .irq(irq));

// ---- dv/core_model.sv ----
// Processor core model driving the watchdog event lines.
// Assumes a bench that calls its tasks and gates the periodic clear.
`timescale 1ns/1ps

module core_model #(
  parameter int KICK = 300
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Periodic clear enable.
  input wire logic kick_en,
  // Event lines.
  output logic clear_watchdog_instruction,
  output logic halt_instruction,
  output logic sleep_mode,
  output logic reset_pin_n
);
  int cnt;
  initial begin
    halt_instruction = 1'b0;
    sleep_mode = 1'b0;
    reset_pin_n = 1'b1;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      clear_watchdog_instruction <= 1'b0;
    end else begin
      cnt <= (kick_en && cnt < KICK - 1) ? cnt + 1 : 0;
      clear_watchdog_instruction <= kick_en && cnt == KICK - 1;
    end
  end
  task automatic pulse_halt;
    @(posedge mclk);
    halt_instruction <= 1'b1;
    @(posedge mclk);
    halt_instruction <= 1'b0;
  endtask
  task automatic set_lines(input logic s, input logic p);
    @(posedge mclk);
    sleep_mode <= s;
    reset_pin_n <= p;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for keyed_watchdog with a core model.
// Assumes design, checker and core model are compiled first.
`timescale 1ns/1ps

module tb_top;
  logic mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, kick_en;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic clr_i, halt_i, sleep_i, pin_n, dev_rst, pcsp_rst, irq;
  int fails = 0;
  int compares = 0;
  int cyc_cnt = 0;
  int since = 0;
  int lat = 0;
  int n_dev = 0;
  int n_pcsp = 0;

  keyed_watchdog #(.OSC_DIV(2), .SOFT_RESET_CYCLES(4)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clear_watchdog_instruction(clr_i),
    .halt_instruction(halt_i), .sleep_mode(sleep_i), .reset_pin_n(pin_n),
    .device_reset(dev_rst), .pc_sp_reset(pcsp_rst), .irq(irq));
  core_model core_u (.mclk(mclk), .arst_n(arst_n), .kick_en(kick_en),
    .clear_watchdog_instruction(clr_i), .halt_instruction(halt_i),
    .sleep_mode(sleep_i), .reset_pin_n(pin_n));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Tracks cycles since the last clear and counts reset pulses.
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    since <= (clr_i || halt_i || dev_rst || pcsp_rst) ? 0 : since + 1;
    if (dev_rst || pcsp_rst) lat <= since;
    n_dev <= n_dev + dev_rst;
    n_pcsp <= n_pcsp + pcsp_rst;
    if (cyc_cnt == 14000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'hF;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    kick_en = 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rdc(6'h00, 8'h53);
    rdc(6'h04, 8'h00);
    rdc(6'h3C, 8'h00);
    $display("test reset done");
    bus(1'b1, 6'h14, 8'h07);
    bus(1'b1, 6'h00, 8'h50);
    kick_en <= 1'b1;
    repeat (1500) @(posedge mclk);
    chk(n_dev, 0);
    kick_en <= 1'b0;
    repeat (600) @(posedge mclk);
    kick_en <= 1'b1;
    chk(n_dev, 1);
    chk(lat >= 509 && lat <= 516, 1);
    chk(irq, 1);
    rdc(6'h08, 8'h05);
    rdc(6'h0C, 8'h01);
    bus(1'b1, 6'h10, 8'h01);
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    $display("test overflow done");
    core_u.set_lines(1'b1, 1'b1);
    kick_en <= 1'b0;
    repeat (600) @(posedge mclk);
    chk(n_pcsp, 1);
    chk(n_dev, 1);
    core_u.set_lines(1'b0, 1'b1);
    core_u.pulse_halt();
    rdc(6'h08, 8'h06);
    kick_en <= 1'b1;
    repeat (400) @(posedge mclk);
    rdc(6'h08, 8'h04);
    $display("test sleep halt done");
    kick_en <= 1'b0;
    core_u.set_lines(1'b0, 1'b0);
    repeat (1200) @(posedge mclk);
    chk(n_dev + n_pcsp, 2);
    core_u.set_lines(1'b0, 1'b1);
    kick_en <= 1'b1;
    bus(1'b1, 6'h00, 8'hA8);
    kick_en <= 1'b0;
    repeat (1200) @(posedge mclk);
    chk(n_dev, 1);
    rdc(6'h08, 8'h00);
    $display("test pin disable done");
    bus(1'b1, 6'h00, 8'hFF);
    repeat (10) @(posedge mclk);
    chk(n_dev, 2);
    rdc(6'h04, 8'h01);
    rdc(6'h00, 8'h53);
    bus(1'b1, 6'h04, 8'h01);
    rdc(6'h04, 8'h01);
    bus(1'b1, 6'h04, 8'h00);
    rdc(6'h04, 8'h00);
    rdc(6'h0C, 8'h06);
    $display("test key reset done");
    bus(1'b1, 6'h00, 8'h51);
    core_u.pulse_halt();
    repeat (2200) @(posedge mclk);
    chk(n_dev, 3);
    chk(lat >= 2045 && lat <= 2052, 1);
    $display("test halt resume done");
    test_done();
  end
endmodule
